/* File: src/bfb_pkg.sv */
package bfb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_RX_BOC_STATUS = 8'h38;
    localparam logic [7:0] ADR_TX_STATUS     = 8'h3a;
    localparam logic [7:0] ADR_TX_INT_EN     = 8'h3b;
    localparam logic [7:0] ADR_RX_BOC_CTL    = 8'h40;
    localparam logic [7:0] ADR_TX_BOC_CTL    = 8'h41;
    localparam logic [7:0] ADR_RX_BOC_CODE   = 8'h42;
    localparam logic [7:0] ADR_TX_BOC_CODE   = 8'h43;
    localparam logic [7:0] ADR_RX_AF_CAP     = 8'h50;
    localparam logic [7:0] REG_RESET         = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TXS_LOSS     = 0;
    localparam int TXS_RESTORED = 1;
    localparam int TXS_MF       = 2;
    localparam int TXS_PDV_AF   = 3;
    localparam int RXS_DETECTED = 0;
    localparam int RXS_CLEAR    = 1;
    localparam int RBC_RESET    = 7;
    localparam int RBC_CLR_LSB  = 4;
    localparam int RBC_VAL_LSB  = 1;
    localparam int TBC_SEND     = 6;

    // ------------------------------------------------------------
    // Timing and coding
    // ------------------------------------------------------------
    localparam logic [3:0] CLK_ACT_PERIODS = 4'hf;
    localparam logic [4:0] PDV_MAX_ZEROS   = 5'h0f;
    localparam int FRAME_US  = 125;
    localparam int SF_MF_US  = 1500;
    localparam int ESF_MF_US = 3000;
    localparam int E1_MF_US  = 2000;
    localparam logic [4:0] FRAMES_SF  = 5'(SF_MF_US / FRAME_US);
    localparam logic [4:0] FRAMES_ESF = 5'(ESF_MF_US / FRAME_US);
    localparam logic [4:0] FRAMES_E1  = 5'(E1_MF_US / FRAME_US);
    localparam logic [7:0] IDLE_CODE  = 8'h7e;
    localparam logic [7:0] BOC_FLAG   = 8'hff;
    localparam logic [3:0] IDLE_LAST  = 4'h7;
    localparam logic [3:0] BOC_LAST   = 4'hf;
    localparam logic [2:0] VAL_7_OF_10 = 3'h4;
    localparam logic [3:0] VAL_HITS    = 4'h7;

    typedef enum logic [1:0] {
        BFB_HUNT = 2'b01,
        BFB_LOCK = 2'b10
    } bfb_boc_state_t;

endpackage

/* File: src/bfb_skid_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module bfb_skid_buf #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    typedef struct packed {
        logic         out_valid;
        logic [W-1:0] out_data;
        logic         skid_valid;
        logic [W-1:0] skid_data;
    } bfb_buf_t;

    bfb_buf_t s;
    bfb_buf_t n;

    // Second entry only fills while the head is stalled
    always_comb begin
        n = s;
        if (!s.out_valid || out_ready) begin
            if (s.skid_valid) begin
                n.out_valid  = 1'b1;
                n.out_data   = s.skid_data;
                n.skid_valid = 1'b0;
            end else begin
                n.out_valid = in_valid;
                n.out_data  = in_data;
            end
        end else if (in_valid && !s.skid_valid) begin
            n.skid_valid = 1'b1;
            n.skid_data  = in_data;
        end
        if (!rst_b) begin
            n = '0;
        end
    end

    always_ff @(posedge clk) begin
        s <= n;
    end

    assign in_ready  = !s.skid_valid;
    assign out_valid = s.out_valid;
    assign out_data  = s.out_data;
endmodule
`default_nettype wire

/* File: src/bfb_boc_status.sv */
// Functional notes
// - DS1 multiframe flag every 1.5 ms in SF, every 3 ms in ESF.
// - E1 multiframe flag every 2 ms at multiframe boundary.
// - Multiframe flag stays set until software writes one; zero leaves it.
// - Clock-restored flag set after clock toggles about 15 master clocks.
// - Clock-loss flag set after about 15 master clocks without transition.
// - Status bits: loss 0, restored 1, multiframe 2, density or align 3.
// - Each transmit status flag drives interrupt only while its enable bit is one.
// - Enables: density or align bit 3, multiframe bit 2, all reset zero.
// - Rising edge of BOC reset bit 7 resets receive BOC logic.
// - Filter field changes apply only after a BOC reset.
// - Clear filter 00..11 gives 16/32/48/64 bits before BOC clear flag.
// - Validation: one, 3, 5, 7 in a row, or 7 of 10.
// - Clear filter at bits 5:4, validation field at bits 3:1.
// - Send-BOC bit 6 one repeats stored BOC; zero sends no BOC.
// - With send-BOC zero, idle pattern 01111110 goes out continuously.
// - Six code bits fill the sixteen-bit message, bit 0 first.
// - Validated BOC stored with first received bit at bit 0, detected set.
// - E1 align capture: international bit at 7, alignment word at 6:0.
// - Align capture loads at align frame start, with receive align flag.
// - Line type zero selects DS1, one selects E1.
// - In E1, status bit 3 sets every 250 us at align frame.
`timescale 1ns/1ps
`default_nettype none
module bfb_boc_status
    import bfb_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST_B,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR_EN,
    input  wire logic       RD_EN,
    output logic [7:0]      RDATA,
    input  wire logic       LINE_TYPE_SELECT,
    input  wire logic       FORMAT_ESF,
    input  wire logic       TX_CLK_SRC,
    input  wire logic       TX_FRAME_START,
    input  wire logic       TX_DATA_BIT,
    input  wire logic       TX_DATA_VALID,
    input  wire logic       RX_DL_BIT,
    input  wire logic       RX_DL_VALID,
    input  wire logic       RX_AF_START,
    input  wire logic [7:0] RX_AF_BYTE,
    output logic            TX_DL_BIT,
    output logic            TX_DL_VALID,
    input  wire logic       TX_DL_READY,
    output logic            INTERRUPT_REQUEST_OUT
);
    typedef struct packed {
        logic [3:0]     tx_status;
        logic [3:0]     tx_int_en;
        logic           rx_boc_reset_bit;
        logic [1:0]     clr_cfg;
        logic [2:0]     val_cfg;
        logic [1:0]     clr_act;
        logic [2:0]     val_act;
        logic           send_boc;
        logic [5:0]     tx_code;
        logic [5:0]     rx_code;
        logic [1:0]     rx_status;
        logic [7:0]     af_cap;
        logic [7:0]     rdata;
        logic           irq;
        logic           clk_prev;
        logic [3:0]     idle_cnt;
        logic [3:0]     act_cnt;
        logic           clk_lost;
        logic [4:0]     frame_cnt;
        logic [4:0]     zero_run;
        bfb_boc_state_t boc_state;
        logic [15:0]    shreg;
        logic [3:0]     slot_cnt;
        logic [5:0]     cand;
        logic [2:0]     run_cnt;
        logic [9:0]     hist;
        logic           boc_active;
        logic [6:0]     clr_cnt;
        logic [15:0]    gen_word;
        logic [3:0]     gen_idx;
        logic [3:0]     gen_last;
    } bfb_state_t;

    bfb_state_t  s;
    bfb_state_t  n;
    logic        e1;
    logic        ds1_esf;
    logic [3:0]  tx_set;
    logic [3:0]  tx_clr;
    logic [1:0]  rx_set;
    logic [1:0]  rx_clr;
    logic [4:0]  mf_last;
    logic [15:0] sh;
    logic        msg_ok;
    logic        hit;
    logic        miss;
    logic        met;
    logic        buf_in_ready;

    function automatic logic [3:0] bfb_ones(input logic [9:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 10; i++) begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction

    always_comb begin
        n       = s;
        e1      = LINE_TYPE_SELECT;
        ds1_esf = !e1 && FORMAT_ESF;
        tx_set  = 4'h0;
        tx_clr  = 4'h0;
        rx_set  = 2'h0;
        rx_clr  = 2'h0;
        mf_last = 5'h0;
        sh      = {RX_DL_BIT, s.shreg[15:1]};
        msg_ok  = 1'b0;
        hit     = 1'b0;
        miss    = 1'b0;
        met     = 1'b0;

        // ------------------------------------------------------------
        // Transmit clock activity monitor
        // ------------------------------------------------------------
        n.clk_prev = TX_CLK_SRC;
        if (TX_CLK_SRC != s.clk_prev) begin
            n.idle_cnt = 4'h0;
        end else if (s.idle_cnt != CLK_ACT_PERIODS) begin
            n.idle_cnt = s.idle_cnt + 4'h1;
        end
        if (n.idle_cnt == CLK_ACT_PERIODS) begin
            n.act_cnt = 4'h0;
            if (!s.clk_lost) begin
                n.clk_lost       = 1'b1;
                tx_set[TXS_LOSS] = 1'b1;
            end
        end else begin
            if (s.act_cnt != CLK_ACT_PERIODS) begin
                n.act_cnt = s.act_cnt + 4'h1;
            end
            if (s.clk_lost && n.act_cnt == CLK_ACT_PERIODS) begin
                n.clk_lost           = 1'b0;
                tx_set[TXS_RESTORED] = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // Transmit frame and multiframe tracking
        // ------------------------------------------------------------
        if (e1) begin
            mf_last = FRAMES_E1 - 5'h1;
        end else if (FORMAT_ESF) begin
            mf_last = FRAMES_ESF - 5'h1;
        end else begin
            mf_last = FRAMES_SF - 5'h1;
        end
        if (TX_FRAME_START) begin
            if (s.frame_cnt == 5'h0) begin
                tx_set[TXS_MF] = 1'b1;
            end
            if (e1 && !s.frame_cnt[0]) begin
                tx_set[TXS_PDV_AF] = 1'b1;
            end
            n.frame_cnt = (s.frame_cnt >= mf_last) ? 5'h0 : s.frame_cnt + 5'h1;
        end

        // Only the zero-run part of the density check is covered
        if (!e1 && TX_DATA_VALID) begin
            if (TX_DATA_BIT) begin
                n.zero_run = 5'h0;
            end else begin
                if (s.zero_run == PDV_MAX_ZEROS) begin
                    tx_set[TXS_PDV_AF] = 1'b1;
                end
                if (s.zero_run != 5'h1f) begin
                    n.zero_run = s.zero_run + 5'h1;
                end
            end
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (WR_EN) begin
            unique case (ADDR)
                ADR_TX_STATUS:     tx_clr = WDATA[3:0];
                ADR_TX_INT_EN:     n.tx_int_en = WDATA[3:0];
                ADR_RX_BOC_STATUS: rx_clr = WDATA[1:0];
                ADR_RX_BOC_CTL: begin
                    n.rx_boc_reset_bit     = WDATA[RBC_RESET];
                    n.clr_cfg = WDATA[RBC_CLR_LSB +: 2];
                    n.val_cfg = WDATA[RBC_VAL_LSB +: 3];
                end
                ADR_TX_BOC_CTL:    n.send_boc = WDATA[TBC_SEND];
                ADR_TX_BOC_CODE:   n.tx_code = WDATA[5:0];
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // Receive BOC detector
        // ------------------------------------------------------------
        if (n.rx_boc_reset_bit && !s.rx_boc_reset_bit) begin
            n.clr_act    = n.clr_cfg;
            n.val_act    = n.val_cfg;
            n.boc_state  = BFB_HUNT;
            n.shreg      = 16'h0000;
            n.slot_cnt   = 4'h0;
            n.cand       = 6'h00;
            n.run_cnt    = 3'h0;
            n.hist       = 10'h000;
            n.boc_active = 1'b0;
            n.clr_cnt    = 7'h00;
        end else if (ds1_esf && RX_DL_VALID) begin
            n.shreg = sh;
            msg_ok  = !sh[0] && !sh[7] && (sh[15:8] == BOC_FLAG);
            unique case (s.boc_state)
                BFB_HUNT: begin
                    if (msg_ok) begin
                        hit         = 1'b1;
                        n.boc_state = BFB_LOCK;
                        n.slot_cnt  = 4'h0;
                    end
                end
                BFB_LOCK: begin
                    n.slot_cnt = s.slot_cnt + 4'h1;
                    if (s.slot_cnt == BOC_LAST) begin
                        hit  = msg_ok;
                        miss = !msg_ok;
                        if (!msg_ok) begin
                            n.boc_state = BFB_HUNT;
                        end
                    end
                end
                default: n.boc_state = BFB_HUNT;
            endcase
            if (hit && sh[6:1] == s.cand) begin
                n.run_cnt = (s.run_cnt == 3'h7) ? 3'h7 : s.run_cnt + 3'h1;
                n.hist    = {s.hist[8:0], 1'b1};
            end else if (hit) begin
                n.cand    = sh[6:1];
                n.run_cnt = 3'h1;
                n.hist    = 10'h001;
            end else if (miss) begin
                n.run_cnt = 3'h0;
                n.hist    = {s.hist[8:0], 1'b0};
            end
            unique case (s.val_act)
                3'h1:        met = n.run_cnt >= 3'h3;
                3'h2:        met = n.run_cnt >= 3'h5;
                3'h3:        met = n.run_cnt >= 3'h7;
                VAL_7_OF_10: met = bfb_ones(n.hist) >= VAL_HITS;
                default:     met = n.run_cnt >= 3'h1;
            endcase
            // Clear filter: bits counted since the stored code last appeared
            if (s.boc_active) begin
                if (hit && sh[6:1] == s.rx_code) begin
                    n.clr_cnt = 7'h00;
                end else if (s.clr_cnt == {1'b0, s.clr_act, 4'hf}) begin
                    n.boc_active      = 1'b0;
                    rx_set[RXS_CLEAR] = 1'b1;
                end else begin
                    n.clr_cnt = s.clr_cnt + 7'h01;
                end
            end
            if (hit && met && (!s.boc_active || n.cand != s.rx_code)) begin
                n.rx_code            = n.cand;
                rx_set[RXS_DETECTED] = 1'b1;
                n.boc_active         = 1'b1;
                n.clr_cnt            = 7'h00;
            end
        end

        // ------------------------------------------------------------
        // Transmit data link generator
        // ------------------------------------------------------------
        if (ds1_esf && buf_in_ready) begin
            if (s.gen_idx == s.gen_last) begin
                n.gen_idx = 4'h0;
                if (s.send_boc) begin
                    n.gen_word = {BOC_FLAG, 1'b0, s.tx_code, 1'b0};
                    n.gen_last = BOC_LAST;
                end else begin
                    n.gen_word = {8'h00, IDLE_CODE};
                    n.gen_last = IDLE_LAST;
                end
            end else begin
                n.gen_idx = s.gen_idx + 4'h1;
            end
        end

        if (e1 && RX_AF_START) begin
            n.af_cap = RX_AF_BYTE;
        end

        // Set wins over a clear landing in the same cycle
        n.tx_status = (s.tx_status & ~tx_clr) | tx_set;
        n.rx_status = (s.rx_status & ~rx_clr) | rx_set;
        n.irq       = |(n.tx_status & n.tx_int_en);

        // ------------------------------------------------------------
        // Register reads, answered one cycle later
        // ------------------------------------------------------------
        if (RD_EN) begin
            unique case (ADDR)
                ADR_TX_STATUS:     n.rdata = {4'h0, s.tx_status};
                ADR_TX_INT_EN:     n.rdata = {4'h0, s.tx_int_en};
                ADR_RX_BOC_STATUS: n.rdata = {6'h00, s.rx_status};
                ADR_RX_BOC_CTL:    n.rdata = {s.rx_boc_reset_bit, 1'b0, s.clr_cfg, s.val_cfg, 1'b0};
                ADR_TX_BOC_CTL:    n.rdata = {1'b0, s.send_boc, 6'h00};
                ADR_RX_BOC_CODE:   n.rdata = {2'h0, s.rx_code};
                ADR_TX_BOC_CODE:   n.rdata = {2'h0, s.tx_code};
                ADR_RX_AF_CAP:     n.rdata = s.af_cap;
                default:           n.rdata = REG_RESET;
            endcase
        end

        if (!RST_B) begin
            n           = '0;
            n.boc_state = BFB_HUNT;
            n.gen_word  = {8'h00, IDLE_CODE};
            n.gen_last  = IDLE_LAST;
        end
    end

    always_ff @(posedge CLK) begin
        s <= n;
    end

    // ------------------------------------------------------------
    // Output buffer, so a stalled receiver loses no bit
    // ------------------------------------------------------------
    bfb_skid_buf #(
        .W (1)
    ) u_dl_buf (
        .clk       (CLK),
        .rst_b     (RST_B),
        .in_valid  (ds1_esf),
        .in_data   (s.gen_word[s.gen_idx]),
        .in_ready  (buf_in_ready),
        .out_valid (TX_DL_VALID),
        .out_data  (TX_DL_BIT),
        .out_ready (TX_DL_READY)
    );

    assign RDATA                 = s.rdata;
    assign INTERRUPT_REQUEST_OUT = s.irq;
endmodule
`default_nettype wire

/* File: bench/bfb_boc_status_props.sv */
`timescale 1ns/1ps
`default_nettype none
module bfb_boc_status_props
    import bfb_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST_B,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR_EN,
    input wire logic       RD_EN,
    input wire logic [7:0] RDATA,
    input wire logic       LINE_TYPE_SELECT,
    input wire logic       RX_AF_START,
    input wire logic [7:0] RX_AF_BYTE,
    input wire logic       TX_DL_BIT,
    input wire logic       TX_DL_VALID,
    input wire logic       TX_DL_READY,
    input wire logic       INTERRUPT_REQUEST_OUT
);
    logic [3:0] en_q;

    // Shadow of the enable bits, so a readback can be judged without the design
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            en_q <= 4'h0;
        end else if (WR_EN && ADDR == ADR_TX_INT_EN) begin
            en_q <= WDATA[3:0];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence af_load_s;
        RX_AF_START && LINE_TYPE_SELECT;
    endsequence
    sequence af_read_s;
        RD_EN && !RX_AF_START && ADDR == ADR_RX_AF_CAP;
    endsequence

    hold_bit_a: assert property (TX_DL_VALID && !TX_DL_READY |=> TX_DL_VALID && $stable(TX_DL_BIT))
        else $error("link bit dropped before acceptance");
    rdata_hold_a: assert property (!RD_EN |=> $stable(RDATA))
        else $error("read data moved without a read");
    unmapped_rd_a: assert property (RD_EN && ADDR == 8'hff |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    status_rsvd_a: assert property (RD_EN && ADDR == ADR_TX_STATUS |=> RDATA[7:4] == 4'h0)
        else $error("status upper bits set");
    code_rsvd_a: assert property (RD_EN && ADDR == ADR_RX_BOC_CODE |=> RDATA[7:6] == 2'b00)
        else $error("received code upper bits set");
    en_readback_a: assert property (RD_EN && !WR_EN && ADDR == ADR_TX_INT_EN |=> RDATA == {4'h0, en_q})
        else $error("enable readback wrong");
    af_capture_a: assert property (af_load_s ##1 af_read_s |=> RDATA == $past(RX_AF_BYTE, 2))
        else $error("align capture wrong");
    irq_mask_a: assert property (WR_EN && ADDR == ADR_TX_INT_EN && WDATA == 8'h00 |-> ##[1:2] !INTERRUPT_REQUEST_OUT)
        else $error("masked interrupt still high");
    link_quiet_a: assert property ((LINE_TYPE_SELECT && TX_DL_READY)[*6] |-> !TX_DL_VALID)
        else $error("data link active in E1");
endmodule

bind bfb_boc_status bfb_boc_status_props i_bfb_boc_status_props (
    .CLK, .RST_B, .ADDR, .WDATA, .WR_EN, .RD_EN, .RDATA, .LINE_TYPE_SELECT, .RX_AF_START,
    .RX_AF_BYTE, .TX_DL_BIT, .TX_DL_VALID, .TX_DL_READY, .INTERRUPT_REQUEST_OUT
);
`default_nettype wire

/* File: bench/bfb_dl_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module bfb_dl_sink (
    input  wire logic   clk,
    input  wire logic   rst_b,
    input  wire logic   stall,
    input  wire logic   dl_bit,
    input  wire logic   dl_valid,
    output logic        dl_ready,
    output logic [15:0] last16,
    output int          n_bits
);
    logic [1:0] ph = 2'h0;
    logic       rdy = 1'b0;

    assign dl_ready = rdy;

    // Stalling takes one bit in three, so the source must hold each bit
    always @(negedge clk) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        rdy <= !stall || ph == 2'h0;
    end

    // Newest bit enters at the top, so a word's first bit ends at bit 0
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            last16 <= 16'h0000;
            n_bits <= 0;
        end else if (dl_valid && dl_ready) begin
            last16 <= {dl_bit, last16[15:1]};
            n_bits <= n_bits + 1;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bfb_pkg::*;
    logic        CLK = 1'b0, RST_B = 1'b0, WR_EN = 1'b0, RD_EN = 1'b0;
    logic        LINE_TYPE_SELECT = 1'b0, FORMAT_ESF = 1'b0, TX_CLK_SRC = 1'b0;
    logic        TX_FRAME_START = 1'b0, RX_DL_BIT = 1'b0, RX_DL_VALID = 1'b0;
    logic        RX_AF_START = 1'b0, stall = 1'b0, clk_run = 1'b1, TX_DATA_VALID = 1'b0;
    logic        TX_DL_BIT, TX_DL_VALID, TX_DL_READY, INTERRUPT_REQUEST_OUT;
    logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, RX_AF_BYTE = 8'h00, RDATA;
    logic [15:0] last16;
    int          n_bits, miscompares = 0, n_compared = 0;

    bfb_boc_status i_bfb_boc_status (
        .CLK, .RST_B, .ADDR, .WDATA, .WR_EN, .RD_EN, .RDATA, .LINE_TYPE_SELECT,
        .FORMAT_ESF, .TX_CLK_SRC, .TX_FRAME_START, .TX_DATA_BIT(1'b0),
        .TX_DATA_VALID, .RX_DL_BIT, .RX_DL_VALID, .RX_AF_START, .RX_AF_BYTE,
        .TX_DL_BIT, .TX_DL_VALID, .TX_DL_READY, .INTERRUPT_REQUEST_OUT
    );
    bfb_dl_sink i_bfb_dl_sink (
        .clk(CLK), .rst_b(RST_B), .stall, .dl_bit(TX_DL_BIT), .dl_valid(TX_DL_VALID),
        .dl_ready(TX_DL_READY), .last16, .n_bits
    );

    initial forever #2 CLK = ~CLK;
    always @(negedge CLK) if (clk_run) TX_CLK_SRC <= ~TX_CLK_SRC;

    // ------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset(input logic lt, input logic esf);
        @(negedge CLK);
        RST_B = 1'b0;
        LINE_TYPE_SELECT = lt;
        FORMAT_ESF = esf;
        repeat (6) @(negedge CLK);
        RST_B = 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        ADDR = a;
        WDATA = d;
        WR_EN = 1'b1;
        @(negedge CLK);
        WR_EN = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLK);
        ADDR = a;
        RD_EN = 1'b1;
        @(negedge CLK);
        RD_EN = 1'b0;
        check({8'h00, RDATA}, {8'h00, e});
    endtask
    task automatic wait_bits(input int n);
        for (int k = 0; k < 3000 && n_bits < n; k++) begin
            @(negedge CLK);
        end
    endtask
    task automatic rx_send(input logic [15:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge CLK);
            RX_DL_BIT = w[i % 16];
            RX_DL_VALID = 1'b1;
            @(negedge CLK);
            RX_DL_VALID = 1'b0;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [7:0] map [8] = '{ADR_TX_INT_EN, ADR_RX_BOC_CTL, ADR_TX_BOC_CTL, ADR_RX_BOC_CODE,
            ADR_TX_BOC_CODE, ADR_RX_AF_CAP, ADR_RX_BOC_STATUS, ADR_TX_STATUS};
        do_reset(1'b0, 1'b1);
        foreach (map[i]) rdc(map[i], REG_RESET);
        rdc(8'hff, 8'h00);
        wr(ADR_TX_INT_EN, 8'hff);
        rdc(ADR_TX_INT_EN, 8'h0f);
        wr(ADR_TX_BOC_CODE, 8'hff);
        rdc(ADR_TX_BOC_CODE, 8'h3f);
        wr(ADR_RX_BOC_CODE, 8'h15);
        rdc(ADR_RX_BOC_CODE, 8'h00);
    endtask
    task automatic t_mf(input logic lt, input logic esf, input int per);
        do_reset(lt, esf);
        for (int i = 0; i <= per; i++) begin
            @(negedge CLK);
            TX_FRAME_START = 1'b1;
            @(negedge CLK);
            TX_FRAME_START = 1'b0;
            wr(ADR_TX_STATUS, 8'h00);
            rdc(ADR_TX_STATUS, {4'h0, lt && i % 2 == 0, i % per == 0, 2'b00});
            wr(ADR_TX_STATUS, 8'h0c);
        end
    endtask
    task automatic t_clk;
        do_reset(1'b0, 1'b0);
        TX_DATA_VALID = 1'b1;
        repeat (16) @(negedge CLK);
        TX_DATA_VALID = 1'b0;
        rdc(ADR_TX_STATUS, 8'h08);
        wr(ADR_TX_STATUS, 8'h08);
        wr(ADR_TX_INT_EN, 8'h02);
        clk_run = 1'b0;
        repeat (20) @(negedge CLK);
        check({15'h0, INTERRUPT_REQUEST_OUT}, 16'h0000);
        rdc(ADR_TX_STATUS, 8'h01);
        wr(ADR_TX_INT_EN, 8'h01);
        repeat (2) @(negedge CLK);
        check({15'h0, INTERRUPT_REQUEST_OUT}, 16'h0001);
        clk_run = 1'b1;
        repeat (20) @(negedge CLK);
        rdc(ADR_TX_STATUS, 8'h03);
        wr(ADR_TX_STATUS, 8'h01);
        repeat (2) @(negedge CLK);
        check({15'h0, INTERRUPT_REQUEST_OUT}, 16'h0000);
        wr(ADR_TX_INT_EN, 8'h02);
        repeat (2) @(negedge CLK);
        check({15'h0, INTERRUPT_REQUEST_OUT}, 16'h0001);
        wr(ADR_TX_INT_EN, 8'h00);
        rdc(ADR_TX_STATUS, 8'h02);
    endtask
    task automatic t_link;
        logic [15:0] exp;
        int          n;
        exp = {8'hff, 1'b0, 6'h25, 1'b0};
        do_reset(1'b0, 1'b1);
        stall = 1'b1;
        wait_bits(24);
        check(last16, {IDLE_CODE, IDLE_CODE});
        wr(ADR_TX_BOC_CODE, 8'h25);
        wr(ADR_TX_BOC_CTL, 8'h40);
        n = n_bits / 8 * 8;
        for (int k = 0; k < 12 && last16 !== exp; k++) begin
            n += 8;
            wait_bits(n);
        end
        check(last16, exp);
        wait_bits(n + 16);
        check(last16, exp);
        wr(ADR_TX_BOC_CTL, 8'h00);
        wait_bits(n + 64);
        check(last16, {IDLE_CODE, IDLE_CODE});
        stall = 1'b0;
    endtask
    task automatic t_rx;
        logic [15:0] msg, m5;
        msg = {8'hff, 1'b0, 6'h1a, 1'b0};
        m5 = {8'hff, 1'b0, 6'h05, 1'b0};
        do_reset(1'b0, 1'b1);
        wr(ADR_RX_BOC_CTL, 8'h02);
        wr(ADR_RX_BOC_CTL, 8'h82);
        rx_send(msg, 32);
        rdc(ADR_RX_BOC_STATUS, 8'h00);
        rx_send(msg, 16);
        rdc(ADR_RX_BOC_CODE, 8'h1a);
        rdc(ADR_RX_BOC_STATUS, 8'h01);
        rx_send({IDLE_CODE, IDLE_CODE}, 32);
        rdc(ADR_RX_BOC_STATUS, 8'h03);
        wr(ADR_RX_BOC_CTL, 8'h00);
        rx_send(m5, 16);
        rdc(ADR_RX_BOC_CODE, 8'h1a);
        wr(ADR_RX_BOC_STATUS, 8'h03);
        wr(ADR_RX_BOC_CTL, 8'h98);
        rx_send(m5, 96);
        rdc(ADR_RX_BOC_STATUS, 8'h00);
        rx_send(m5, 16);
        rdc(ADR_RX_BOC_CODE, 8'h05);
        rx_send({IDLE_CODE, IDLE_CODE}, 24);
        rdc(ADR_RX_BOC_STATUS, 8'h01);
        rx_send({IDLE_CODE, IDLE_CODE}, 8);
        rdc(ADR_RX_BOC_STATUS, 8'h03);
    endtask
    task automatic t_af;
        logic [7:0] bytes [2] = '{8'h9b, 8'h1b};
        do_reset(1'b1, 1'b0);
        foreach (bytes[i]) begin
            @(negedge CLK);
            RX_AF_BYTE = bytes[i];
            RX_AF_START = 1'b1;
            @(negedge CLK);
            RX_AF_START = 1'b0;
            RX_AF_BYTE = 8'h00;
            ADDR = ADR_RX_AF_CAP;
            RD_EN = 1'b1;
            @(negedge CLK);
            RD_EN = 1'b0;
            check({8'h00, RDATA}, {8'h00, bytes[i]});
        end
    endtask

    initial begin
        t_regs();
        t_mf(1'b0, 1'b0, 12);
        t_mf(1'b0, 1'b1, 24);
        t_mf(1'b1, 1'b0, 16);
        t_clk();
        t_link();
        t_rx();
        t_af();
        end_sim();
    end

    // Run needs about 1500 cycles; 50000 cycles bounds a hang
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
